/* pco_clock_config.sv */
// synthesizer divider, reference output, pre-emphasis and trigger output configuration
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - reference clock output is active when its enable bit and synthesizer enable are set
// - reference output enable bit resets to one so the output starts unprogrammed
// - second divider code 0,1,2 divides by 1,2,4; code 3 reserved
// - first divider code 0,1,2 divides by 5,4,3; code 3 reserved
// - third divider divides by its programmed value 1 to 63, reset value 32
// - one four-bit pre-emphasis code drives every serial lane together
// - trigger control resets to zero: enable bit 7, reserved 6:3, mode 2:0
// - trigger buffer and divider run only while the trigger enable is one
// - trigger mode selects 16, 32, 64 UI clock or resampled timestamp
module pco_clock_config
   import pco_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic spi_sclk,
   input wire logic spi_csn,
   input wire logic spi_sdi,
   output logic spi_sdo,
   output logic spi_sdo_oe_n,
   input wire logic synth_enable,
   input wire logic synth_reset_bit,
   input wire logic serializer_ui_tick,
   input wire logic timestamp_input,
   output logic synth_reference_clock_output,
   output pco_pkg::pco_divider_t synth_divider,
   output logic [pco_pkg::BIAS_W-1:0] oscillator_bias,
   output logic [pco_pkg::LANES*pco_pkg::PREEMPH_W-1:0] lane_preemphasis,
   output logic trigger_out_enable,
   output logic trigger_clock_output
);
   import pco_pkg::*;

   typedef struct packed {
      logic [NUM_REGS-1:0][DATA_W-1:0] regs;
      logic ref_active;
      pco_divider_t divider;
      logic [BIAS_W-1:0] bias;
      logic [PREEMPH_W-1:0] preemph;
      logic trig_enable;
      logic [5:0] trig_count;
      logic trig_level;
      logic [1:0] stamp_sync;
   } pco_cfg_state_t;

   pco_cfg_state_t s;
   pco_cfg_state_t next_s;
   pco_spi_req_t req;
   logic [DATA_W-1:0] rdata;
   logic [3:0] rd_hit;
   logic [3:0] wr_hit;
   logic [11:0] ratio_product;
   logic [5:0] half_period;
   logic [DATA_W-1:0] trig_reg;

   // address decode shared by the read and write paths: bit 3 is the hit, bits 2:0 the index
   function automatic logic [3:0] reg_lookup(input logic [ADDR_W-1:0] addr);
      logic [3:0] hit;
      hit = 4'h0;
      for (int i = 0; i < NUM_REGS; i++) begin
         if (addr == REG_OFFSETS[i]) begin
            hit = {1'b1, 3'(i)};
         end
      end
      return hit;
   endfunction

   function automatic logic [2:0] first_ratio(input logic [DIV_SEL_W-1:0] code);
      logic [2:0] r;
      unique case (code)
         2'h0: r = 3'h5;
         2'h1: r = 3'h4;
         2'h2: r = 3'h3;
         default: r = 3'h0;
      endcase
      return r;
   endfunction

   function automatic logic [2:0] second_ratio(input logic [DIV_SEL_W-1:0] code);
      logic [2:0] r;
      unique case (code)
         2'h0: r = 3'h1;
         2'h1: r = 3'h2;
         2'h2: r = 3'h4;
         default: r = 3'h0;
      endcase
      return r;
   endfunction

   pco_spi_slave u_spi (
      .clk(clk),
      .reset(reset),
      .spi_sclk(spi_sclk),
      .spi_csn(spi_csn),
      .spi_sdi(spi_sdi),
      .spi_sdo(spi_sdo),
      .spi_sdo_oe_n(spi_sdo_oe_n),
      .req(req),
      .rdata(rdata)
   );

   always_comb begin
      next_s = s;
      rd_hit = reg_lookup(req.addr);
      wr_hit = reg_lookup(req.addr);
      ratio_product = 12'h000;
      half_period = TRIG_HALF_UI16;
      trig_reg = s.regs[IDX_TRIG];

      // all bits, reserved ones too, are stored and read back as written
      rdata = rd_hit[3] ? s.regs[rd_hit[2:0]] : 8'h00;
      if (req.wr && wr_hit[3]) begin
         next_s.regs[wr_hit[2:0]] = req.wdata;
      end

      next_s.ref_active = s.regs[IDX_REF_OUT][REF_EN_BIT] & synth_enable;

      // divider settings only pass to the synthesizer while its reset holds, so a
      // half-written divider set never reaches a locked loop
      if (synth_reset_bit) begin
         next_s.divider.v_ratio = first_ratio(s.regs[IDX_FBDIV_VP][V_DIV_LSB +: DIV_SEL_W]);
         next_s.divider.p_ratio = second_ratio(s.regs[IDX_FBDIV_VP][P_DIV_LSB +: DIV_SEL_W]);
         next_s.divider.n_ratio = s.regs[IDX_FBDIV_N][N_DIV_LSB +: N_DIV_W];
         ratio_product = next_s.divider.v_ratio * next_s.divider.p_ratio * next_s.divider.n_ratio;
         next_s.divider.feedback_ratio = ratio_product[10:0];
         // reserved selector codes and a zero third divider are flagged, not guessed at
         next_s.divider.valid = (ratio_product != 12'h000);
      end

      next_s.bias = s.regs[IDX_BIAS][BIAS_LSB +: BIAS_W];
      next_s.preemph = s.regs[IDX_PREEMPH][PREEMPH_LSB +: PREEMPH_W];

      // timestamp pin is asynchronous to clk
      next_s.stamp_sync = {s.stamp_sync[0], timestamp_input};

      next_s.trig_enable = trig_reg[TRIG_EN_BIT];
      if (!trig_reg[TRIG_EN_BIT]) begin
         next_s.trig_count = 6'h00;
         next_s.trig_level = 1'b0;
      end else begin
         unique case (trig_reg[TRIG_SEL_LSB +: TRIG_SEL_W])
            TRIG_SEL_UI16: half_period = TRIG_HALF_UI16;
            TRIG_SEL_UI32: half_period = TRIG_HALF_UI32;
            TRIG_SEL_UI64: half_period = TRIG_HALF_UI64;
            default: half_period = TRIG_HALF_UI16;
         endcase
         if (trig_reg[TRIG_SEL_LSB +: TRIG_SEL_W] == TRIG_SEL_TIMESTAMP) begin
            next_s.trig_count = 6'h00;
            next_s.trig_level = s.stamp_sync[1];
         end else if (trig_reg[TRIG_SEL_LSB +: TRIG_SEL_W] > TRIG_SEL_TIMESTAMP) begin
            // reserved selections keep the output quiet
            next_s.trig_count = 6'h00;
            next_s.trig_level = 1'b0;
         end else if (serializer_ui_tick) begin
            // a mode change while running is not guarded; the count simply restarts at the next wrap
            if (s.trig_count >= half_period - 6'h01) begin
               next_s.trig_count = 6'h00;
               next_s.trig_level = ~s.trig_level;
            end else begin
               next_s.trig_count = s.trig_count + 6'h01;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s <= '0;
         s.regs <= REG_RESET;
         s.divider.v_ratio <= 3'h5;
         s.divider.p_ratio <= 3'h1;
         s.divider.n_ratio <= 6'h20;
         s.divider.feedback_ratio <= 11'h0a0;
         s.divider.valid <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign synth_reference_clock_output = s.ref_active;
   assign synth_divider = s.divider;
   assign oscillator_bias = s.bias;
   assign trigger_out_enable = s.trig_enable;
   assign trigger_clock_output = s.trig_level;

   // one common code fans out to every lane
   for (genvar g = 0; g < LANES; g++) begin : g_lane
      assign lane_preemphasis[g*PREEMPH_W +: PREEMPH_W] = s.preemph;
   end

endmodule
`default_nettype wire

/* pco_clock_config_sva.sv */
// assertions for the synthesizer and clock output configuration block
`timescale 1ns/1ns
`default_nettype none
module pco_clock_config_sva
   import pco_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic synth_enable,
   input wire logic synth_reset_bit,
   input wire logic synth_reference_clock_output,
   input wire pco_pkg::pco_divider_t synth_divider,
   input wire logic [pco_pkg::BIAS_W-1:0] oscillator_bias,
   input wire logic [pco_pkg::LANES*pco_pkg::PREEMPH_W-1:0] lane_preemphasis,
   input wire logic trigger_out_enable,
   input wire logic trigger_clock_output
);
   import pco_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   property p_ref_off; !synth_enable |=> !synth_reference_clock_output; endproperty
   a_ref_off: assert property (p_ref_off) else $error("ref output on while synth off");
   // no write can land this early, so the output comes up unprogrammed
   property p_ref_on; $fell(reset) && synth_enable ##1 synth_enable[*2] |=> synth_reference_clock_output; endproperty
   a_ref_on: assert property (p_ref_on) else $error("ref output not on after reset");
   property p_lanes; lane_preemphasis == {LANES{lane_preemphasis[PREEMPH_W-1:0]}}; endproperty
   a_lanes: assert property (p_lanes) else $error("lanes differ in pre-emphasis");
   property p_trig_off; !trigger_out_enable[*4] |-> !trigger_clock_output; endproperty
   a_trig_off: assert property (p_trig_off) else $error("trigger output runs while disabled");
   property p_div_hold; !synth_reset_bit |=> $stable(synth_divider); endproperty
   a_div_hold: assert property (p_div_hold) else $error("divider changed outside reset");
   property p_ratio;
      synth_divider.valid |-> synth_divider.v_ratio inside {3'h3, 3'h4, 3'h5} && synth_divider.n_ratio != 6'h00
         && synth_divider.p_ratio inside {3'h1, 3'h2, 3'h4}
         && synth_divider.feedback_ratio == synth_divider.v_ratio * synth_divider.p_ratio * synth_divider.n_ratio;
   endproperty
   a_ratio: assert property (p_ratio) else $error("divider ratio decode wrong");
   property p_trig_rst; $fell(reset) |-> !trigger_out_enable && !trigger_clock_output; endproperty
   a_trig_rst: assert property (p_trig_rst) else $error("trigger not off after reset");
   property p_defaults;
      $fell(reset) |-> ##2 synth_divider.n_ratio == 6'h20 && synth_divider.feedback_ratio == 11'h0a0
         && oscillator_bias == 7'h4f;
   endproperty
   a_defaults: assert property (p_defaults) else $error("defaults wrong after reset");
   c_trig: cover property ($rose(trigger_clock_output));
   c_div: cover property (synth_reset_bit ##1 $changed(synth_divider));
   c_ref: cover property ($fell(synth_reference_clock_output));
endmodule
bind pco_clock_config pco_clock_config_sva chk (.clk(clk), .reset(reset), .synth_enable(synth_enable),
   .synth_reset_bit(synth_reset_bit), .synth_reference_clock_output(synth_reference_clock_output),
   .synth_divider(synth_divider), .oscillator_bias(oscillator_bias), .lane_preemphasis(lane_preemphasis),
   .trigger_out_enable(trigger_out_enable), .trigger_clock_output(trigger_clock_output));
`default_nettype wire

/* pco_pkg.sv */
// shared constants and carrier types for the clock synthesizer and clock output configuration block
package pco_pkg;

   // serial register frame: one read flag, fifteen address bits, eight data bits
   localparam int unsigned ADDR_W = 15;
   localparam int unsigned DATA_W = 8;
   localparam logic [4:0] CMD_LAST_BIT = 5'h0f;
   localparam logic [4:0] FRAME_LAST_BIT = 5'h17;

   // register offsets
   localparam int unsigned NUM_REGS = 6;
   localparam logic [2:0] IDX_REF_OUT = 3'h0;
   localparam logic [2:0] IDX_FBDIV_VP = 3'h1;
   localparam logic [2:0] IDX_FBDIV_N = 3'h2;
   localparam logic [2:0] IDX_BIAS = 3'h3;
   localparam logic [2:0] IDX_PREEMPH = 3'h4;
   localparam logic [2:0] IDX_TRIG = 3'h5;
   localparam logic [NUM_REGS-1:0][ADDR_W-1:0] REG_OFFSETS = {
      15'h0057, 15'h0048, 15'h003f, 15'h003e, 15'h003d, 15'h003c};

   // values after reset, in index order from the right
   localparam logic [NUM_REGS-1:0][DATA_W-1:0] REG_RESET = {
      8'h00, 8'h00, 8'h4f, 8'h20, 8'h00, 8'h01};

   // field positions
   localparam int unsigned REF_EN_BIT = 0;
   localparam int unsigned V_DIV_LSB = 0;
   localparam int unsigned P_DIV_LSB = 2;
   localparam int unsigned DIV_SEL_W = 2;
   localparam int unsigned N_DIV_LSB = 0;
   localparam int unsigned N_DIV_W = 6;
   localparam int unsigned BIAS_LSB = 0;
   localparam int unsigned BIAS_W = 7;
   localparam int unsigned PREEMPH_LSB = 0;
   localparam int unsigned PREEMPH_W = 4;
   localparam int unsigned TRIG_EN_BIT = 7;
   localparam int unsigned TRIG_SEL_LSB = 0;
   localparam int unsigned TRIG_SEL_W = 3;

   // serial output lanes sharing one pre-emphasis code
   localparam int unsigned LANES = 8;

   // trigger output selections and half periods counted in unit intervals
   localparam logic [2:0] TRIG_SEL_UI16 = 3'h0;
   localparam logic [2:0] TRIG_SEL_UI32 = 3'h1;
   localparam logic [2:0] TRIG_SEL_UI64 = 3'h2;
   localparam logic [2:0] TRIG_SEL_TIMESTAMP = 3'h3;
   localparam logic [5:0] TRIG_HALF_UI16 = 6'h08;
   localparam logic [5:0] TRIG_HALF_UI32 = 6'h10;
   localparam logic [5:0] TRIG_HALF_UI64 = 6'h20;

   typedef enum logic [2:0] {SPI_IDLE, SPI_CMD, SPI_LOAD, SPI_DATA, SPI_DONE} pco_spi_phase_t;

   typedef struct packed {
      logic wr;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } pco_spi_req_t;

   typedef struct packed {
      logic valid;
      logic [2:0] v_ratio;
      logic [2:0] p_ratio;
      logic [5:0] n_ratio;
      logic [10:0] feedback_ratio;
   } pco_divider_t;

endpackage

/* pco_spi_host.sv */
// serial register host model sending mode 0 frames
`timescale 1ns/1ns
`default_nettype none
module pco_spi_host (
   input wire logic clk,
   output logic spi_sclk,
   output logic spi_csn,
   output logic spi_sdi,
   input wire logic spi_sdo,
   input wire logic spi_sdo_oe_n
);
   // six clk a phase leaves margin over the minimum and the sdo sync delay
   localparam int PH = 6;
   initial begin
      spi_sclk = 1'b0;
      spi_csn = 1'b1;
      spi_sdi = 1'b0;
   end
   task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] wd, output logic [7:0] q);
      logic [23:0] f;
      f = {rd, a, wd};
      q = 8'h00;
      @(posedge clk) #1 spi_csn = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         spi_sdi = f[i];
         repeat (PH) @(posedge clk);
         #1;
         if (i < 8 && !spi_sdo_oe_n) q[i] = spi_sdo;
         spi_sclk = 1'b1;
         repeat (PH) @(posedge clk);
         #1 spi_sclk = 1'b0;
      end
      repeat (PH) @(posedge clk);
      #1 spi_csn = 1'b1;
      // released data line must not keep the last bit
      spi_sdi = ~spi_sdi;
      repeat (8) @(posedge clk);
      // hand back just after an edge so callers never drive on the sampling edge
      #1;
   endtask
endmodule
`default_nettype wire

/* pco_spi_slave.sv */
// serial register port: oversampled frame receiver and read data shifter
`timescale 1ns/1ns
`default_nettype none
module pco_spi_slave
   import pco_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic spi_sclk,
   input wire logic spi_csn,
   input wire logic spi_sdi,
   output logic spi_sdo,
   output logic spi_sdo_oe_n,
   output pco_pkg::pco_spi_req_t req,
   input wire logic [pco_pkg::DATA_W-1:0] rdata
);
   import pco_pkg::*;

   typedef struct packed {
      logic [1:0] sclk_sync;
      logic [1:0] csn_sync;
      logic [1:0] sdi_sync;
      logic sclk_prev;
      pco_spi_phase_t phase;
      logic [4:0] count;
      logic [23:0] shift;
      logic [DATA_W-1:0] rd_shift;
      logic sdo;
      logic sdo_oe_n;
      pco_spi_req_t req;
   } pco_spi_state_t;

   pco_spi_state_t s;
   pco_spi_state_t next_s;
   logic rise;
   logic fall;

   always_comb begin
      next_s = s;
      // only the second stage of each synchroniser feeds logic
      next_s.sclk_sync = {s.sclk_sync[0], spi_sclk};
      next_s.csn_sync = {s.csn_sync[0], spi_csn};
      next_s.sdi_sync = {s.sdi_sync[0], spi_sdi};
      next_s.sclk_prev = s.sclk_sync[1];
      next_s.req.wr = 1'b0;
      rise = s.sclk_sync[1] & ~s.sclk_prev;
      fall = ~s.sclk_sync[1] & s.sclk_prev;
      if (s.csn_sync[1]) begin
         next_s.phase = SPI_IDLE;
         next_s.count = 5'h00;
         next_s.sdo_oe_n = 1'b1;
         next_s.sdo = 1'b0;
      end else begin
         unique case (s.phase)
            SPI_IDLE: begin
               next_s.phase = SPI_CMD;
               next_s.count = 5'h00;
               next_s.sdo_oe_n = 1'b0;
            end
            SPI_CMD: begin
               if (rise) begin
                  next_s.shift = {s.shift[22:0], s.sdi_sync[1]};
                  next_s.count = s.count + 5'h01;
                  if (s.count == CMD_LAST_BIT) begin
                     next_s.req.addr = next_s.shift[ADDR_W-1:0];
                     next_s.phase = SPI_LOAD;
                  end
               end
            end
            // address is registered now, so the register file answers this cycle
            SPI_LOAD: begin
               next_s.rd_shift = s.shift[ADDR_W] ? rdata : 8'h00;
               next_s.phase = SPI_DATA;
            end
            SPI_DATA: begin
               if (fall) begin
                  next_s.sdo = s.rd_shift[DATA_W-1];
                  next_s.rd_shift = {s.rd_shift[DATA_W-2:0], 1'b0};
               end
               if (rise) begin
                  next_s.shift = {s.shift[22:0], s.sdi_sync[1]};
                  next_s.count = s.count + 5'h01;
                  if (s.count == FRAME_LAST_BIT) begin
                     next_s.req.wdata = next_s.shift[DATA_W-1:0];
                     next_s.req.wr = ~s.shift[22];
                     next_s.phase = SPI_DONE;
                  end
               end
            end
            SPI_DONE: begin
               next_s.phase = SPI_DONE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s <= '0;
         s.sdo_oe_n <= 1'b1;
         s.csn_sync <= 2'h3;
         s.phase <= SPI_IDLE;
      end else begin
         s <= next_s;
      end
   end

   assign spi_sdo = s.sdo;
   assign spi_sdo_oe_n = s.sdo_oe_n;
   assign req = s.req;

endmodule
`default_nettype wire

/* test_pll_clock_output_config.sv */
// self-checking bench for the clock configuration block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin n_fail++; \
   $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module test_pll_clock_output_config;
   import pco_pkg::*;
   logic clk, reset, sclk, csn, sdi, sdo, sdo_oe_n, s_en, s_rst, ts, ref_out, trig_en, trig_out;
   logic tick = 1'b0;
   logic [6:0] bias;
   logic [31:0] lanes;
   logic [7:0] q;
   pco_divider_t div;
   int n_fail = 0;
   int tests_run = 0;
   int n;
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) #1 tick = ~tick;
   pco_clock_config dut (.clk(clk), .reset(reset), .spi_sclk(sclk), .spi_csn(csn), .spi_sdi(sdi),
      .spi_sdo(sdo), .spi_sdo_oe_n(sdo_oe_n), .synth_enable(s_en), .synth_reset_bit(s_rst),
      .serializer_ui_tick(tick), .timestamp_input(ts), .synth_reference_clock_output(ref_out),
      .synth_divider(div), .oscillator_bias(bias), .lane_preemphasis(lanes),
      .trigger_out_enable(trig_en), .trigger_clock_output(trig_out));
   pco_spi_host host (.clk(clk), .spi_sclk(sclk), .spi_csn(csn), .spi_sdi(sdi), .spi_sdo(sdo),
      .spi_sdo_oe_n(sdo_oe_n));
   task automatic step(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      logic [7:0] x;
      host.xfer(1'b0, a, d, x);
      step(2);
   endtask
   task automatic rd(input logic [14:0] a, input logic [7:0] e);
      host.xfer(1'b1, a, 8'h00, q);
      `CHK("read", e, q)
   endtask
   task automatic hi_len(output int c);
      c = 0;
      // skip a high phase already under way, so only a whole one is timed
      repeat (300) if (trig_out) step(1);
      repeat (300) if (!trig_out) step(1);
      while (trig_out && c < 300) begin
         step(1);
         c++;
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #200000;
      n_fail++;
      conclude();
   end
   initial begin
      reset = 1'b1; s_en = 1'b1; s_rst = 1'b0; ts = 1'b0;
      repeat (2) @(posedge clk);
      #1 reset = 1'b0;
      step(3);
      `CHK("ref", 1'b1, ref_out)
      for (int i = 0; i < NUM_REGS; i++) rd(REG_OFFSETS[i], REG_RESET[i]);
      rd(15'h0040, 8'h00);
      wr(15'h003c, 8'h00);
      `CHK("ref", 1'b0, ref_out)
      wr(15'h003c, 8'h01);
      s_en = 1'b0;
      step(2);
      `CHK("ref", 1'b0, ref_out)
      s_en = 1'b1;
      wr(15'h003d, 8'h05);
      `CHK("v held", 3'h5, div.v_ratio)
      s_rst = 1'b1;
      for (int c = 0; c < 4; c++) begin
         wr(15'h003d, 8'({c[1:0], c[1:0]}));
         `CHK("valid", c < 3, div.valid)
         if (c < 3) begin
            `CHK("v", 3'(5 - c), div.v_ratio)
            `CHK("p", 3'(1 << c), div.p_ratio)
         end
      end
      wr(15'h003d, 8'h00);
      wr(15'h003e, 8'h3f);
      `CHK("fb", 11'h13b, div.feedback_ratio)
      wr(15'h003e, 8'h01);
      `CHK("fb", 11'h005, div.feedback_ratio)
      s_rst = 1'b0;
      wr(15'h003e, 8'h20);
      `CHK("n held", 6'h01, div.n_ratio)
      wr(15'h003f, 8'h4a);
      `CHK("bias", 7'h4a, bias)
      wr(15'h0048, 8'h0b);
      `CHK("lanes", {LANES{4'hb}}, lanes)
      for (int m = 0; m < 3; m++) begin
         wr(15'h0057, 8'(m));
         wr(15'h0057, 8'(8'h80 | m));
         hi_len(n);
         `CHK("trig high", 16 << m, n)
         `CHK("trig en", 1'b1, trig_en)
         wr(15'h0057, 8'(m));
         `CHK("trig off", 1'b0, trig_out)
         `CHK("trig en off", 1'b0, trig_en)
      end
      wr(15'h0057, 8'h03);
      wr(15'h0057, 8'h83);
      rd(15'h0057, 8'h83);
      ts = 1'b1;
      step(6);
      `CHK("stamp", 1'b1, trig_out)
      ts = 1'b0;
      step(6);
      `CHK("stamp", 1'b0, trig_out)
      wr(15'h0057, 8'h03);
      wr(15'h0057, 8'h04);
      wr(15'h0057, 8'h84);
      step(80);
      `CHK("reserved mode", 1'b0, trig_out)
      conclude();
   end
endmodule
`default_nettype wire
